// file: dsp_field_decoder.sv
// Instruction field decoder with pointer, program counter and bus selects
`timescale 1ns/1ps
module dsp_field_decoder (
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic [23:0] instr_i,
    input wire logic instr_valid_i,
    input wire logic [5:0] flags_a_i,
    input wire logic [5:0] flags_b_i,
    input wire logic serial_in_ack_i,
    input wire logic serial_out_ack_i,
    input wire logic host_transfer_request_i,
    input wire logic [15:0] temp_register_b_i,
    input wire logic [15:0] acc_a_i,
    input wire logic [15:0] acc_b_i,
    input wire logic [15:0] temp_register_i,
    input wire logic [15:0] coef_table_output_i,
    input wire logic [15:0] saturation_sign_value_i,
    input wire logic [15:0] host_data_register_i,
    input wire logic [15:0] status_word_i,
    input wire logic [15:0] serial_in_shift_reg_i,
    input wire logic [15:0] operand_k_i,
    input wire logic [15:0] operand_l_i,
    input wire logic [15:0] ram_data_i,
    output logic [1:0] instr_class_o,
    output logic accumulator_choice_o,
    output logic carry_in_o,
    output logic [15:0] bus_o,
    output logic [3:0] source_select_o,
    output logic host_read_o,
    output logic [15:0] load_en_o,
    output logic [15:0] operand_k_value_o,
    output logic [15:0] operand_l_value_o,
    output logic [15:0] serial_out_word_o,
    output logic [7:0] data_pointer_o,
    output logic [7:0] ram_alt_addr_o,
    output logic [9:0] table_pointer_o,
    output logic [10:0] pc_o
);
    // ------------------------------------------------------------------
    // Field extraction
    // ------------------------------------------------------------------
    wire logic [1:0] opc = instr_i[dfd_pkg::OPC_HI:dfd_pkg::OPC_LO];
    wire logic is_op = instr_valid_i && (opc == dfd_pkg::OPC_OP ||
        opc == dfd_pkg::OPC_RT);
    wire logic is_rt = instr_valid_i && (opc == dfd_pkg::OPC_RT);
    wire logic is_jp = instr_valid_i && (opc == dfd_pkg::OPC_JP);
    wire logic is_ld = instr_valid_i && (opc == dfd_pkg::OPC_LD);
    wire logic acc_sel = instr_i[dfd_pkg::ACC_BIT];
    wire logic [1:0] plo_op = instr_i[dfd_pkg::PLO_HI:dfd_pkg::PLO_LO];
    wire logic [3:0] phi_xor = instr_i[dfd_pkg::PHI_HI:dfd_pkg::PHI_LO];
    wire logic tstep = instr_i[dfd_pkg::TSTEP_BIT];
    wire logic [3:0] src = instr_i[dfd_pkg::SRC_HI:dfd_pkg::SRC_LO];
    wire logic [3:0] dst = instr_i[dfd_pkg::DST_HI:dfd_pkg::DST_LO];
    wire logic [8:0] brc = instr_i[dfd_pkg::BR_HI:dfd_pkg::BR_LO];
    wire logic [10:0] target = instr_i[dfd_pkg::TGT_HI:dfd_pkg::TGT_LO];
    wire logic [15:0] imm = instr_i[dfd_pkg::IMM_HI:dfd_pkg::IMM_LO];

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [7:0] dp_ff;
    logic [9:0] tp_ff;
    logic [10:0] pc_ff;
    logic [2:0] sp_ff;
    logic [10:0] stack_ff [dfd_pkg::STK_DEPTH];
    logic [1:0] class_ff;
    logic acc_ff;
    logic carry_ff;
    logic [15:0] bus_ff;
    logic [3:0] src_ff;
    logic host_rd_ff;
    logic [15:0] load_ff;
    logic [15:0] k_ff;
    logic [15:0] l_ff;
    logic [15:0] so_ff;
    logic [7:0] alt_ff;

    // Bit reversal shared by serial in and out orders
    function automatic logic [15:0] dfd_rev16(input logic [15:0] v);
        logic [15:0] r;
        r = 16'h0000;
        for (int i = 0; i < 16; i++) begin
            r[i] = v[15 - i];
        end
        return r;
    endfunction : dfd_rev16

    // ------------------------------------------------------------------
    // Bus source selection
    // ------------------------------------------------------------------
    logic [15:0] src_val;
    always_comb begin
        case (src)
            dfd_pkg::SRC_TRB: src_val = temp_register_b_i;
            dfd_pkg::SRC_ACCA: src_val = acc_a_i;
            dfd_pkg::SRC_ACCB: src_val = acc_b_i;
            dfd_pkg::SRC_TR: src_val = temp_register_i;
            dfd_pkg::SRC_DP: src_val = {8'h00, dp_ff};
            dfd_pkg::SRC_TP: src_val = {6'h00, tp_ff};
            dfd_pkg::SRC_ROM: src_val = coef_table_output_i;
            dfd_pkg::SRC_SGN: src_val = saturation_sign_value_i;
            dfd_pkg::SRC_HOST: src_val = host_data_register_i;
            dfd_pkg::SRC_HOSTNF: src_val = host_data_register_i;
            dfd_pkg::SRC_STAT: src_val = status_word_i;
            // Shift register fills from bit 0, so first bit ends at 15
            dfd_pkg::SRC_SIM: src_val = serial_in_shift_reg_i;
            dfd_pkg::SRC_SIL: begin
                src_val = dfd_rev16(serial_in_shift_reg_i);
            end
            dfd_pkg::SRC_K: src_val = operand_k_i;
            dfd_pkg::SRC_L: src_val = operand_l_i;
            default: src_val = ram_data_i;
        endcase
    end

    // Immediate loads drive the bus with their data field
    wire logic [15:0] bus_val = is_ld ? imm : src_val;
    wire logic drives = is_op || is_ld;
    wire logic [15:0] dst_onehot = 16'h0001 << dst;
    wire logic [15:0] nxt_load = (drives && dst != dfd_pkg::DST_NONE) ?
        dst_onehot : 16'h0000;

    // Operand loads, with the paired loads for the combined codes
    wire logic [15:0] nxt_k = (dst == dfd_pkg::DST_KLM) ? ram_data_i :
        bus_val;
    wire logic [15:0] nxt_l = (dst == dfd_pkg::DST_KLR) ?
        coef_table_output_i : bus_val;
    wire logic [15:0] nxt_so = (dst == dfd_pkg::DST_SOM) ?
        dfd_rev16(bus_val) : bus_val;
    wire logic [7:0] nxt_alt = {dp_ff[7], 1'b1, dp_ff[5:0]};

    // ------------------------------------------------------------------
    // Pointer updates
    // ------------------------------------------------------------------
    logic [3:0] nxt_plo;
    always_comb begin
        case (plo_op)
            dfd_pkg::PLO_INC: nxt_plo = dp_ff[3:0] + 4'h1;
            dfd_pkg::PLO_DEC: nxt_plo = dp_ff[3:0] - 4'h1;
            dfd_pkg::PLO_CLR: nxt_plo = 4'h0;
            default: nxt_plo = dp_ff[3:0];
        endcase
    end
    wire logic [7:0] dp_mod = {dp_ff[7:4] ^ phi_xor, nxt_plo};
    wire logic dp_bus_ld = drives && dst == dfd_pkg::DST_DP;
    wire logic tp_bus_ld = drives && dst == dfd_pkg::DST_TP;
    wire logic [7:0] nxt_dp = dp_bus_ld ? bus_val[7:0] :
        (is_op ? dp_mod : dp_ff);
    wire logic [9:0] nxt_tp = tp_bus_ld ? bus_val[9:0] :
        ((is_op && tstep) ? tp_ff - 10'h001 : tp_ff);

    // ------------------------------------------------------------------
    // Branch and program counter
    // ------------------------------------------------------------------
    logic take;
    logic call;
    dfd_branch_eval u_branch (
        .branch_condition_i(brc),
        .flags_a_i(flags_a_i),
        .flags_b_i(flags_b_i),
        .pointer_low_i(dp_ff[3:0]),
        .serial_in_ack_i(serial_in_ack_i),
        .serial_out_ack_i(serial_out_ack_i),
        .host_transfer_request_i(host_transfer_request_i),
        .take_o(take),
        .call_o(call)
    );
    wire logic [10:0] pc_inc = pc_ff + 11'h001;
    wire logic do_call = is_jp && call && sp_ff < 3'(dfd_pkg::STK_DEPTH);
    wire logic do_ret = is_rt && sp_ff != 3'h0;
    wire logic [2:0] sp_dn = sp_ff - 3'h1;
    wire logic [10:0] ret_addr = stack_ff[sp_dn[1:0]];
    wire logic [10:0] nxt_pc = !instr_valid_i ? pc_ff :
        (is_jp && take) ? target :
        do_ret ? ret_addr : pc_inc;
    wire logic [2:0] nxt_sp = do_call ? sp_ff + 3'h1 :
        (do_ret ? sp_dn : sp_ff);

    // Carry comes from the other accumulator's flags (bit 0 is carry)
    wire logic nxt_carry = acc_sel ? flags_a_i[0] : flags_b_i[0];

    // ------------------------------------------------------------------
    // Architectural state; new pointers seen by next instruction
    // ------------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            dp_ff <= dfd_pkg::DP_RST;
            tp_ff <= dfd_pkg::TP_RST;
            pc_ff <= dfd_pkg::PC_RST;
            sp_ff <= dfd_pkg::SP_RST;
        end else begin
            dp_ff <= nxt_dp;
            tp_ff <= nxt_tp;
            pc_ff <= nxt_pc;
            sp_ff <= nxt_sp;
        end
    end

    // Return stack storage
    always_ff @(posedge clock_i) begin
        if (do_call) begin
            stack_ff[sp_ff[1:0]] <= pc_inc;
        end
    end

    // Registered decode outputs
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            class_ff <= dfd_pkg::OPC_OP;
            acc_ff <= 1'b0;
            carry_ff <= 1'b0;
            bus_ff <= 16'h0000;
            src_ff <= dfd_pkg::SRC_TRB;
            host_rd_ff <= 1'b0;
            load_ff <= 16'h0000;
            k_ff <= 16'h0000;
            l_ff <= 16'h0000;
            so_ff <= 16'h0000;
            alt_ff <= 8'h00;
        end else begin
            class_ff <= opc;
            acc_ff <= acc_sel;
            carry_ff <= nxt_carry;
            bus_ff <= bus_val;
            src_ff <= src;
            host_rd_ff <= is_op && src == dfd_pkg::SRC_HOST;
            load_ff <= nxt_load;
            k_ff <= nxt_k;
            l_ff <= nxt_l;
            so_ff <= nxt_so;
            alt_ff <= nxt_alt;
        end
    end

    // Output drive
    assign instr_class_o = class_ff;
    assign accumulator_choice_o = acc_ff;
    assign carry_in_o = carry_ff;
    assign bus_o = bus_ff;
    assign source_select_o = src_ff;
    assign host_read_o = host_rd_ff;
    assign load_en_o = load_ff;
    assign operand_k_value_o = k_ff;
    assign operand_l_value_o = l_ff;
    assign serial_out_word_o = so_ff;
    assign data_pointer_o = dp_ff;
    assign ram_alt_addr_o = alt_ff;
    assign table_pointer_o = tp_ff;
    assign pc_o = pc_ff;
endmodule : dsp_field_decoder

// file: dfd_pkg.sv
// Constants and field layout of the instruction field decoder
// Operation
// - Bit 15 picks accumulator A (0) or B (1) for the ALU.
// - Carry for add/subtract with carry comes from the unselected accumulator.
// - Bits 14:13 on pointer low nibble: hold, increment, decrement, clear.
// - Pointer bits 7:4 are XORed with instruction bits 12:9.
// - Bit 8 set decrements the table pointer, else it holds.
// - Source codes 0-7: tempB, accA, accB, temp, ptr, table ptr, ROM, sign.
// - Source codes 8-15: host data, host no flag, status, serial in M/L, K, L, RAM.
// - Source code "none" still drives temp register B onto the bus.
// - Host data no-flag read leaves the transfer-request flag alone.
// - MSB-first serial read puts first bit at bus bit 15.
// - LSB-first serial read puts first bit at bus bit 0.
// - Dest codes 0-7: none, accA, accB, temp, ptr, table, host, status.
// - Dest codes 8-15: serial out L/M, K, K+ROM, L+RAM, L, tempB, RAM.
// - LSB-first serial output shifts from bus bit 0 upward.
// - MSB-first serial output shifts from bus bit 15 downward.
// - K+ROM load: K takes bus, L takes ROM output in same instruction.
// - L+RAM load: L takes bus, K takes RAM at pointer with bit 6 set.
// - Branch field 100000000 jumps, 101000000 calls, both unconditional.
// - Flag jumps 010xyzab0: flag select, accumulator B bit, jump-on-one bit.
// - Pointer-low jumps compare with zero or F; bit 13 inverts sense.
// - Serial-in ack, serial-out ack, host request jumps; second code tests one.
// - Top two bits class: operate, operate+return, jump, immediate load.
// - Jump target is bits 12:2, an 11-bit address.
// - Pointer changes take effect from the next instruction.
package dfd_pkg;
    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int OPC_HI = 23;
    localparam int OPC_LO = 22;
    localparam int ACC_BIT = 15;
    localparam int PLO_HI = 14;
    localparam int PLO_LO = 13;
    localparam int PHI_HI = 12;
    localparam int PHI_LO = 9;
    localparam int TSTEP_BIT = 8;
    localparam int SRC_HI = 7;
    localparam int SRC_LO = 4;
    localparam int DST_HI = 3;
    localparam int DST_LO = 0;
    localparam int BR_HI = 21;
    localparam int BR_LO = 13;
    localparam int TGT_HI = 12;
    localparam int TGT_LO = 2;
    localparam int IMM_HI = 21;
    localparam int IMM_LO = 6;
    // ------------------------------------------------------------------
    // Widths, depths and reset values
    // ------------------------------------------------------------------
    localparam int PC_W = 11;
    localparam int STK_DEPTH = 4;
    localparam int STK_PTR_W = 2;
    localparam logic [7:0] DP_RST = 8'h00;
    localparam logic [9:0] TP_RST = 10'h000;
    localparam logic [10:0] PC_RST = 11'h000;
    localparam logic [2:0] SP_RST = 3'h0;
    // ------------------------------------------------------------------
    // Instruction classes
    // ------------------------------------------------------------------
    localparam logic [1:0] OPC_OP = 2'h0;
    localparam logic [1:0] OPC_RT = 2'h1;
    localparam logic [1:0] OPC_JP = 2'h2;
    localparam logic [1:0] OPC_LD = 2'h3;
    // ------------------------------------------------------------------
    // Pointer low operations
    // ------------------------------------------------------------------
    localparam logic [1:0] PLO_NOP = 2'h0;
    localparam logic [1:0] PLO_INC = 2'h1;
    localparam logic [1:0] PLO_DEC = 2'h2;
    localparam logic [1:0] PLO_CLR = 2'h3;
    // ------------------------------------------------------------------
    // Source and destination codes
    // ------------------------------------------------------------------
    localparam logic [3:0] SRC_TRB = 4'h0;
    localparam logic [3:0] SRC_ACCA = 4'h1;
    localparam logic [3:0] SRC_ACCB = 4'h2;
    localparam logic [3:0] SRC_TR = 4'h3;
    localparam logic [3:0] SRC_DP = 4'h4;
    localparam logic [3:0] SRC_TP = 4'h5;
    localparam logic [3:0] SRC_ROM = 4'h6;
    localparam logic [3:0] SRC_SGN = 4'h7;
    localparam logic [3:0] SRC_HOST = 4'h8;
    localparam logic [3:0] SRC_HOSTNF = 4'h9;
    localparam logic [3:0] SRC_STAT = 4'ha;
    localparam logic [3:0] SRC_SIM = 4'hb;
    localparam logic [3:0] SRC_SIL = 4'hc;
    localparam logic [3:0] SRC_K = 4'hd;
    localparam logic [3:0] SRC_L = 4'he;
    localparam logic [3:0] SRC_RAM = 4'hf;
    localparam logic [3:0] DST_NONE = 4'h0;
    localparam logic [3:0] DST_ACCA = 4'h1;
    localparam logic [3:0] DST_ACCB = 4'h2;
    localparam logic [3:0] DST_TR = 4'h3;
    localparam logic [3:0] DST_DP = 4'h4;
    localparam logic [3:0] DST_TP = 4'h5;
    localparam logic [3:0] DST_HOST = 4'h6;
    localparam logic [3:0] DST_STAT = 4'h7;
    localparam logic [3:0] DST_SOL = 4'h8;
    localparam logic [3:0] DST_SOM = 4'h9;
    localparam logic [3:0] DST_K = 4'ha;
    localparam logic [3:0] DST_KLR = 4'hb;
    localparam logic [3:0] DST_KLM = 4'hc;
    localparam logic [3:0] DST_L = 4'hd;
    localparam logic [3:0] DST_TRB = 4'he;
    localparam logic [3:0] DST_RAM = 4'hf;
    // ------------------------------------------------------------------
    // Branch codes
    // ------------------------------------------------------------------
    localparam logic [8:0] BR_JMP = 9'h100;
    localparam logic [8:0] BR_CALL = 9'h140;
    // Top three branch bits shared by all conditional jumps
    localparam logic [2:0] BR_FLAG_TOP = 3'h2;
    localparam logic [2:0] FLG_CARRY = 3'h0;
    localparam logic [2:0] FLG_ZERO = 3'h1;
    localparam logic [2:0] FLG_OV0 = 3'h2;
    localparam logic [2:0] FLG_OV1 = 3'h3;
    localparam logic [2:0] FLG_SGN0 = 3'h4;
    localparam logic [2:0] FLG_SGN1 = 3'h5;
    localparam logic [6:0] BR_PLO_TOP = 7'h2c;
    localparam logic [6:0] BR_SERIAL_IN_ACK_TOP = 7'h2d;
    localparam logic [6:0] BR_SOACK_TOP = 7'h2e;
    localparam logic [6:0] BR_RQM_TOP = 7'h2f;
    localparam logic [3:0] NIB_ALL1 = 4'hf;
    localparam logic [3:0] NIB_ZERO = 4'h0;
endpackage : dfd_pkg

// file: dfd_branch_eval.sv
// Branch condition evaluator for jump instructions
`timescale 1ns/1ps
module dfd_branch_eval (
    input wire logic [8:0] branch_condition_i,
    input wire logic [5:0] flags_a_i,
    input wire logic [5:0] flags_b_i,
    input wire logic [3:0] pointer_low_i,
    input wire logic serial_in_ack_i,
    input wire logic serial_out_ack_i,
    input wire logic host_transfer_request_i,
    output logic take_o,
    output logic call_o
);
    // ------------------------------------------------------------------
    // Field slices
    // ------------------------------------------------------------------
    wire logic [2:0] flag_sel = branch_condition_i[5:3];
    wire logic use_b = branch_condition_i[2];
    wire logic want_one = branch_condition_i[1];
    wire logic [5:0] flags = use_b ? flags_b_i : flags_a_i;
    wire logic flag_bit = (flag_sel <= dfd_pkg::FLG_SGN1) ?
        flags[flag_sel] : 1'b0;
    wire logic [3:0] cmp_nib = want_one ? dfd_pkg::NIB_ALL1 :
        dfd_pkg::NIB_ZERO;
    wire logic plo_eq = (pointer_low_i == cmp_nib);

    // Unconditional, flag, pointer and handshake conditions
    always_comb begin
        take_o = 1'b0;
        call_o = 1'b0;
        if (branch_condition_i == dfd_pkg::BR_JMP) begin
            take_o = 1'b1;
        end else if (branch_condition_i == dfd_pkg::BR_CALL) begin
            take_o = 1'b1;
            call_o = 1'b1;
        end else if (branch_condition_i[8:6] == dfd_pkg::BR_FLAG_TOP) begin
            case (branch_condition_i[8:2])
                dfd_pkg::BR_PLO_TOP: begin
                    take_o = plo_eq ^ branch_condition_i[0];
                end
                dfd_pkg::BR_SERIAL_IN_ACK_TOP: begin
                    take_o = (serial_in_ack_i == want_one);
                end
                dfd_pkg::BR_SOACK_TOP: begin
                    take_o = (serial_out_ack_i == want_one);
                end
                dfd_pkg::BR_RQM_TOP: begin
                    take_o = (host_transfer_request_i == want_one);
                end
                default: begin
                    take_o = (flag_bit == want_one);
                end
            endcase
        end
    end
endmodule : dfd_branch_eval

// file: dfd_prog_mem.sv
// Program memory model that feeds instruction words by program counter
`timescale 1ns/1ps
module dfd_prog_mem (
    input wire logic [10:0] addr_i,
    output logic [23:0] word_o
);
    // Word store filled by the bench; blank words are no-operation
    logic [23:0] words [2048];
    initial begin
        for (int a = 0; a < 2048; a++) begin
            words[a] = 24'h000000;
        end
    end
    // Combinational fetch at the current program counter
    assign word_o = words[addr_i];
endmodule : dfd_prog_mem

// file: dfd_checker_sva.sv
// Concurrent checks on the field decoder ports
`timescale 1ns/1ps
module dfd_checker (
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic [23:0] instr_i,
    input wire logic instr_valid_i,
    input wire logic [5:0] flags_a_i,
    input wire logic [5:0] flags_b_i,
    input wire logic [15:0] temp_register_b_i,
    input wire logic [15:0] host_data_register_i,
    input wire logic accumulator_choice_o,
    input wire logic carry_in_o,
    input wire logic [15:0] bus_o,
    input wire logic host_read_o,
    input wire logic [15:0] load_en_o,
    input wire logic [7:0] data_pointer_o,
    input wire logic [9:0] table_pointer_o,
    input wire logic [10:0] pc_o
);
    // Operate or return instruction taken at this edge
    wire op = instr_valid_i && !instr_i[23];
    wire [3:0] src = instr_i[7:4];
    wire [3:0] dst = instr_i[3:0];
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);
    a_acc_choice: assert property (
        op |=> accumulator_choice_o == $past(instr_i[15]))
        else $error("accumulator choice wrong");
    a_carry_other: assert property (
        op |=> carry_in_o == ($past(instr_i[15]) ? $past(flags_a_i[0])
        : $past(flags_b_i[0]))) else $error("carry source wrong");
    a_low_clear: assert property (
        op && dst != 4'h4 && instr_i[14:13] == 2'h3
        |=> data_pointer_o[3:0] == 4'h0) else $error("low clear wrong");
    a_high_xor: assert property (
        op && dst != 4'h4 |=> data_pointer_o[7:4] ==
        ($past(data_pointer_o[7:4]) ^ $past(instr_i[12:9])))
        else $error("high nibble wrong");
    a_table_step: assert property (
        op && dst != 4'h5 |=> table_pointer_o ==
        $past(table_pointer_o) - {9'h000, $past(instr_i[8])})
        else $error("table step wrong");
    a_none_drives: assert property (
        op && src == 4'h0 |=> bus_o == $past(temp_register_b_i))
        else $error("none source wrong");
    a_host_noflag: assert property (
        op && src == 4'h9 |=> !host_read_o
        && bus_o == $past(host_data_register_i)) else $error("noflag wrong");
    a_dest_onehot: assert property (
        op |=> load_en_o == ($past(dst) == 4'h0 ? 16'h0000
        : 16'h0001 << $past(dst))) else $error("load enable wrong");
    a_jump_uncond: assert property (
        instr_valid_i && instr_i[23:13] == 11'h500
        |=> pc_o == $past(instr_i[12:2])) else $error("jump wrong");
    // Main scenarios reached
    c_call: cover property (instr_valid_i && instr_i[23:13] == 11'h540);
    c_ram_pair: cover property (op && dst == 4'hc);
    c_serial_in: cover property (op && src == 4'hb);
endmodule : dfd_checker

bind dsp_field_decoder dfd_checker i_chk (.clock_i, .rst_b_i, .instr_i,
    .instr_valid_i, .flags_a_i, .flags_b_i, .temp_register_b_i,
    .host_data_register_i, .accumulator_choice_o, .carry_in_o, .bus_o,
    .host_read_o, .load_en_o, .data_pointer_o, .table_pointer_o, .pc_o);

// file: dfd_tb.sv
// Self-checking bench for the instruction field decoder
`timescale 1ns/1ps
module tb;
    logic clock_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic instr_valid_i = 1'b1;
    logic [5:0] flags_a_i = 6'h15;
    logic [5:0] flags_b_i = 6'h2a;
    logic si_ack = 1'b1;
    logic so_ack = 1'b0;
    logic rq = 1'b1;
    logic [15:0] srcs [16];
    logic [7:0] dp_m = 8'h00;
    logic [9:0] tp_m = 10'h000;
    int n_errors = 0;
    int n_checks = 0;
    wire [23:0] instr_i;
    wire [1:0] cls;
    wire acc;
    wire cin;
    wire hrd;
    wire [3:0] ssel;
    wire [15:0] bus_o, load_en_o, opk, opl, so_w;
    wire [7:0] dp, alt;
    wire [9:0] tp;
    wire [10:0] pc_o;
    always #5 clock_i = ~clock_i;
    dfd_prog_mem i_mem (.addr_i(pc_o), .word_o(instr_i));
    dsp_field_decoder i_dut (.clock_i, .rst_b_i, .instr_i, .instr_valid_i,
        .flags_a_i, .flags_b_i, .serial_in_ack_i(si_ack),
        .serial_out_ack_i(so_ack), .host_transfer_request_i(rq),
        .temp_register_b_i(srcs[0]), .acc_a_i(srcs[1]), .acc_b_i(srcs[2]),
        .temp_register_i(srcs[3]), .coef_table_output_i(srcs[6]),
        .saturation_sign_value_i(srcs[7]), .host_data_register_i(srcs[8]),
        .status_word_i(srcs[10]), .serial_in_shift_reg_i(srcs[11]),
        .operand_k_i(srcs[13]), .operand_l_i(srcs[14]),
        .ram_data_i(srcs[15]), .instr_class_o(cls),
        .accumulator_choice_o(acc), .carry_in_o(cin), .bus_o,
        .source_select_o(ssel), .host_read_o(hrd), .load_en_o,
        .operand_k_value_o(opk), .operand_l_value_o(opl),
        .serial_out_word_o(so_w), .data_pointer_o(dp), .ram_alt_addr_o(alt),
        .table_pointer_o(tp), .pc_o);
    // Compare and count
    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    function automatic logic [15:0] rev(input logic [15:0] v);
        for (int b = 0; b < 16; b++) rev[b] = v[15 - b];
    endfunction : rev
    // One instruction at the current address, outputs settled after
    task run(input logic [23:0] w);
        i_mem.words[pc_o] = w;
        @(posedge clock_i);
        #1;
    endtask : run
    // Every source and destination code, paired code for code
    task t_codes;
        logic [15:0] e;
        for (int k = 0; k < 16; k++) begin
            run({2'b00, 6'h00, k[0], 7'h00, k[3:0], k[3:0]});
            e = (k == 4 || k == 5) ? 16'h0000 : (k == 9) ? srcs[8] :
                (k == 12) ? rev(srcs[11]) : srcs[k];
            chk("bus", e, bus_o);
            chk("src_sel", 16'(k), 16'(ssel));
            e = (k == 0) ? 16'h0000 : 16'(1 << k);
            chk("load_en", e, load_en_o);
            chk("host_rd", 16'(k == 8), 16'(hrd));
            chk("acc", 16'(k % 2), 16'(acc));
            e = 16'(k[0] ? flags_a_i[0] : flags_b_i[0]);
            chk("carry", e, 16'(cin));
            if (k == 8) chk("so_lsb", srcs[8], so_w);
            if (k == 9) chk("so_msb", rev(srcs[8]), so_w);
            if (k == 11) chk("l_rom", srcs[6], opl);
            if (k == 12) chk("k_ram", srcs[15], opk);
            if (k == 11) chk("k_bus", srcs[11], opk);
            if (k == 12) chk("l_bus", rev(srcs[11]), opl);
            if (k == 12) chk("alt", 16'(dp_m | 8'h40), 16'(alt));
        end
    endtask : t_codes
    // Pointer updates, including a low-nibble wrap below zero
    task t_ptr;
        logic [1:0] op;
        logic [3:0] x;
        for (int i = 0; i < 7; i++) begin
            op = 2'(i * 3);
            x = 4'(i * 5);
            run({2'b00, 6'h00, 1'b0, op, x, i[0], 8'h00});
            dp_m[3:0] = (op == 2'h1) ? dp_m[3:0] + 4'h1 :
                (op == 2'h2) ? dp_m[3:0] - 4'h1 :
                (op == 2'h3) ? 4'h0 : dp_m[3:0];
            dp_m[7:4] = dp_m[7:4] ^ x;
            tp_m = tp_m - 10'(i[0]);
            chk("dp", 16'(dp_m), 16'(dp));
            chk("tp", 16'(tp_m), 16'(tp));
        end
    endtask : t_ptr
    task jump(input logic [8:0] br, input logic take);
        logic [10:0] p;
        logic [10:0] t;
        p = pc_o;
        t = p ^ 11'h5a5;
        run({2'b10, br, t, 2'b00});
        chk("pc", 16'(take ? t : p + 11'h001), 16'(pc_o));
    endtask : jump
    // Branch codes; only listed codes are issued
    task t_br;
        logic f;
        logic [10:0] p;
        jump(9'h100, 1'b1);
        for (int c = 0; c < 24; c++) begin
            f = c[1] ? flags_b_i[c >> 2] : flags_a_i[c >> 2];
            jump({3'b010, 3'(c >> 2), c[1], c[0], 1'b0}, f == c[0]);
        end
        for (int c = 0; c < 4; c++) begin
            f = (dp_m[3:0] == (c[1] ? 4'hf : 4'h0)) ^ c[0];
            jump({6'b010110, 1'b0, c[1], c[0]}, f);
        end
        for (int c = 0; c < 6; c++) begin
            f = (c < 2) ? si_ack : (c < 4) ? so_ack : rq;
            jump({7'(7'h2d + c / 2), c[0], 1'b0}, f == c[0]);
        end
        p = pc_o;
        jump(9'h140, 1'b1);
        run({2'b01, 22'h000000});
        chk("ret", 16'(p + 11'h001), 16'(pc_o));
        run({2'b10, 9'h100, 11'h7ff, 2'b00});
        chk("pc_top", 16'h07ff, 16'(pc_o));
        chk("class", 16'h0002, 16'(cls));
        instr_valid_i = 1'b0;
        run(24'h800000);
        chk("pc_hold", 16'h07ff, 16'(pc_o));
        instr_valid_i = 1'b1;
    endtask : t_br
    task end_of_test;
        if (n_errors == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_of_test
    // Reset, then the scenarios in turn
    initial begin
        for (int k = 0; k < 16; k++) srcs[k] = {k[3:0], 12'ha5c};
        repeat (16) @(posedge clock_i);
        #1;
        rst_b_i = 1'b1;
        t_codes();
        t_ptr();
        t_br();
        end_of_test();
    end
endmodule : tb
